// >>> logic/dcr_pkg.sv
// Constants of the four-channel register set: offsets, fields, steps.
// Assumes AXI4-Lite byte addresses relative to the block base.
package dcr_pkg;
   localparam logic [7:0]  OFS_CH0    = 8'h20;
   localparam logic [7:0]  OFS_CH_END = 8'h5F;
   localparam logic [7:0]  OFS_SHARED = 8'h60;
   localparam logic [3:0]  OFS_SRC    = 4'h0;
   localparam logic [3:0]  OFS_DST    = 4'h4;
   localparam logic [3:0]  OFS_CNT    = 4'h8;
   localparam logic [3:0]  OFS_CTL    = 4'hC;
   localparam int          NUM_CH     = 4;
   localparam int          NUM_EXT    = 2;
   localparam int          B_ENA      = 0;
   localparam int          B_TEND     = 1;
   localparam int          B_IEN      = 2;
   localparam int          B_UNIT     = 3;
   localparam int          B_SSTEP    = 12;
   localparam int          B_DSTEP    = 14;
   localparam int          B_SENSE    = 6;
   localparam int          B_REQPOL   = 18;
   localparam int          B_RELOAD   = 19;
   localparam int          B_FETCH    = 20;
   localparam logic [31:0] CTL_RST    = 32'h0;
   localparam logic [31:0] CTL_COMMON = 32'hFF3D;
   localparam logic [31:0] CTL_CH01   = 32'h7_0040;
   localparam logic [31:0] CTL_CH2    = 32'h8_0000;
   localparam logic [31:0] CTL_CH3    = 32'h10_0000;
   localparam logic [15:0] SH_RST     = 16'h0000;
   localparam logic [15:0] SH_WMASK   = 16'h0001;
   localparam int          B_SH_RUN   = 0;
   localparam int          B_SH_FLAG  = 1;
   localparam logic [1:0]  MODE_INC   = 2'h1;
   localparam logic [1:0]  MODE_DEC   = 2'h2;
   localparam logic [1:0]  UNIT_BYTE  = 2'h0;
   localparam logic [1:0]  UNIT_WORD  = 2'h1;
   localparam logic [1:0]  UNIT_LONG  = 2'h2;
   localparam logic [31:0] STEP_BYTE  = 32'h1;
   localparam logic [31:0] STEP_WORD  = 32'h2;
   localparam logic [31:0] STEP_LONG  = 32'h4;
   localparam logic [31:0] STEP_QUAD  = 32'h10;
   localparam logic [1:0]  RELOAD_LAST = 2'h3;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   function automatic logic [31:0] ctl_mask(input int ch);
      ctl_mask = CTL_COMMON;
      if (ch < 2) ctl_mask = ctl_mask | CTL_CH01;
      if (ch == 2) ctl_mask = ctl_mask | CTL_CH2;
      if (ch == 3) ctl_mask = ctl_mask | CTL_CH3;
   endfunction : ctl_mask

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) merge[i*8+:8] = nw[i*8+:8];
      end
   endfunction : merge
endpackage : dcr_pkg

// >>> logic/dcr_reqack.sv
// External request pin sampler with request-accepted strobe.
// Assumes an asynchronous active-low request pin.
`timescale 1ns/10ps
module dcr_reqack (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic req_pin,
   input  wire logic enabled,
   input  wire logic edge_sense,
   input  wire logic pol,
   output logic      accepted
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;
   logic acc_next;
   logic hit;

   always_comb begin
      hit = edge_sense ? (prev_reg & ~sync2_reg) : ~sync2_reg;
      acc_next = pol ? (hit & enabled) : ~(hit & enabled);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         prev_reg  <= 1'b1;
         accepted  <= 1'b1;
      end else begin
         sync1_reg <= req_pin;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
         accepted  <= acc_next;
      end
   end
endmodule : dcr_reqack

// >>> logic/dcr_chan.sv
// One channel: pointers, counter and control word, advanced per unit.
// Assumes step pulses from the transfer engine on the same clock.
`timescale 1ns/10ps
module dcr_chan #(
   parameter int CH    = 0,
   parameter int CNT_W = 24
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wr_src,
   input  wire logic        wr_dst,
   input  wire logic        wr_cnt,
   input  wire logic        wr_ctl,
   input  wire logic        rd_ctl,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        step,
   input  wire logic        run_en,
   output logic      [31:0] src,
   output logic      [31:0] dst,
   output logic      [31:0] cnt,
   output logic      [31:0] ctl
);
   localparam logic [31:0] MASK = dcr_pkg::ctl_mask(CH);
   logic [31:0]      src_reg, src_next, dst_reg, dst_next;
   logic [31:0]      init_reg, init_next, ctl_reg, ctl_next, m;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [1:0]       rl_reg, rl_next;
   logic             arm_reg, arm_next, ended;
   logic [31:0]      unit, sstep;

   function automatic logic [31:0] adv(input logic [31:0] p, input logic [1:0] md,
                                       input logic [31:0] s);
      adv = p;
      if (md == dcr_pkg::MODE_INC) adv = p + s;
      if (md == dcr_pkg::MODE_DEC) adv = p - s;
   endfunction : adv

   always_comb begin
      src_next = src_reg;
      dst_next = dst_reg;
      cnt_next = cnt_reg;
      ctl_next = ctl_reg;
      init_next = init_reg;
      rl_next = rl_reg;
      arm_next = arm_reg;
      ended = 1'b0;
      m = dcr_pkg::merge(ctl_reg, wdata, wstrb);
      unique case (ctl_reg[dcr_pkg::B_UNIT+:2])
         dcr_pkg::UNIT_BYTE: unit = dcr_pkg::STEP_BYTE;
         dcr_pkg::UNIT_WORD: unit = dcr_pkg::STEP_WORD;
         dcr_pkg::UNIT_LONG: unit = dcr_pkg::STEP_LONG;
         default:            unit = dcr_pkg::STEP_QUAD;
      endcase
      sstep = (CH == 3 && ctl_reg[dcr_pkg::B_FETCH]) ? dcr_pkg::STEP_LONG : unit;
      if (step && run_en && ctl_reg[dcr_pkg::B_ENA] && !ctl_reg[dcr_pkg::B_TEND]) begin
         src_next = adv(src_reg, ctl_reg[dcr_pkg::B_SSTEP+:2], sstep);
         dst_next = adv(dst_reg, ctl_reg[dcr_pkg::B_DSTEP+:2], unit);
         cnt_next = CNT_W'(cnt_reg - 1'b1);
         if (CH == 2 && ctl_reg[dcr_pkg::B_RELOAD]) begin
            rl_next = rl_reg + 2'h1;
            if (rl_reg == dcr_pkg::RELOAD_LAST) src_next = init_reg;
         end
         if (cnt_reg == CNT_W'(1)) begin
            ctl_next[dcr_pkg::B_TEND] = 1'b1;
            ended = 1'b1;
         end
      end
      if (rd_ctl && ctl_reg[dcr_pkg::B_TEND]) arm_next = 1'b1;
      if (wr_src) begin
         src_next = dcr_pkg::merge(src_reg, wdata, wstrb);
         init_next = src_next;
         rl_next = 2'h0;
      end
      if (wr_dst) dst_next = dcr_pkg::merge(dst_reg, wdata, wstrb);
      if (wr_cnt) cnt_next = CNT_W'(dcr_pkg::merge(32'(cnt_reg), wdata, wstrb));
      if (wr_ctl) begin
         ctl_next = (m & MASK) | (ctl_next & ~MASK);
         if (wstrb[0] && !wdata[dcr_pkg::B_TEND] && arm_reg && !ended) begin
            ctl_next[dcr_pkg::B_TEND] = 1'b0;
            arm_next = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      src_reg  <= src_next;
      dst_reg  <= dst_next;
      cnt_reg  <= cnt_next;
      init_reg <= init_next;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl_reg <= dcr_pkg::CTL_RST;
         rl_reg  <= 2'h0;
         arm_reg <= 1'b0;
      end else begin
         ctl_reg <= ctl_next;
         rl_reg  <= rl_next;
         arm_reg <= arm_next;
      end
   end

   assign src = src_reg;
   assign dst = dst_reg;
   assign cnt = 32'(cnt_reg);
   assign ctl = ctl_reg;
endmodule : dcr_chan

// >>> logic/dcr_top.sv
// Four-channel DMA register set behind an AXI4-Lite slave.
// Assumes a transfer engine pulsing XFER_STEP per unit moved.
// Notes on behaviour
// - End flags clear by zero-write after reading one
// - Half-word writes keep the other half
// - Counter has 24 bits, upper read zero
// - Source pointer shows next source address
// - Pointers and counter unreset, kept in standby
// - Destination pointer shows next destination address
// - Count one is one, zero is maximum
// - Counter shows remaining units
// - Each 16-byte block decrements once
// - Control word resets zero, kept in standby
// - Channel-specific bits absent elsewhere read zero
// - Bits 31..21 and 7 read zero
// - Channel 3 fetch mode selects indirect addressing
// - Channel 2 reload restores initial source
// - Bit 18 sets accepted-strobe level
// - Polarity zero low-active, one high-active
// - Steps 1,2,4,16 both up and down
// - Indirect source steps by four
`timescale 1ns/10ps
module dcr_top #(
   parameter int ADDR_W = 8,
   parameter int CNT_W  = 24
) (
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic [ADDR_W-1:0] AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [ADDR_W-1:0] ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   input  wire logic [3:0]  XFER_STEP,
   input  wire logic        STANDBY,
   input  wire logic [1:0]  FLAG_SET,
   input  wire logic [1:0]  TRANSFER_REQUEST_PIN,
   output logic [1:0]       REQUEST_ACCEPTED_STROBE,
   output logic [3:0]       CHANNEL_IRQ
);
   localparam int NCH = dcr_pkg::NUM_CH;

   if (ADDR_W < 7 || CNT_W < 2 || CNT_W > 24) begin : g_chk
      $error("bad parameters");
   end

   logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
   logic              aw_have_reg, aw_have_next;
   logic [31:0]       w_data_reg, w_data_next;
   logic [3:0]        w_strb_reg, w_strb_next;
   logic              w_have_reg, w_have_next;
   logic              awready_reg, awready_next;
   logic              wready_reg, wready_next;
   logic              bvalid_reg, bvalid_next;
   logic [1:0]        bresp_reg, bresp_next;
   logic              arready_reg, arready_next;
   logic              rvalid_reg, rvalid_next;
   logic [31:0]       rdata_reg, rdata_next;
   logic [1:0]        rresp_reg, rresp_next;
   logic [15:0]       sh_reg, sh_next;
   logic [1:0]        sh_arm_reg, sh_arm_next;
   logic [3:0]        irq_reg, irq_next;
   logic [NCH-1:0]    wr_src, wr_dst, wr_cnt, wr_ctl, rd_ctl;
   logic [31:0]       src [NCH];
   logic [31:0]       dst [NCH];
   logic [31:0]       cnt [NCH];
   logic [31:0]       ctl [NCH];
   logic              run_en;
   logic              do_write;
   logic              w_ok, w_sh;
   logic [1:0]        w_ch, r_ch;
   logic [3:0]        w_reg, r_reg;
   logic              r_ok, r_sh;
   logic [7:0]        wa, ra;
   logic [7:0]        wrel, rrel;

   // Standby or a raised shared flag freezes every channel
   assign run_en = sh_reg[dcr_pkg::B_SH_RUN] & ~|sh_reg[dcr_pkg::B_SH_FLAG+:2] & ~STANDBY;

   // Address decode for the write and read paths
   always_comb begin
      wa = 8'(aw_addr_reg);
      ra = 8'(ARADDR);
      wrel = wa - dcr_pkg::OFS_CH0;
      rrel = ra - dcr_pkg::OFS_CH0;
      w_ch = wrel[5:4];
      r_ch = rrel[5:4];
      w_reg = wrel[3:0];
      r_reg = rrel[3:0];
      w_sh = (wa == dcr_pkg::OFS_SHARED);
      r_sh = (ra == dcr_pkg::OFS_SHARED);
      w_ok = w_sh || (wa >= dcr_pkg::OFS_CH0 && wa <= dcr_pkg::OFS_CH_END && wa[1:0] == 2'h0);
      r_ok = r_sh || (ra >= dcr_pkg::OFS_CH0 && ra <= dcr_pkg::OFS_CH_END && ra[1:0] == 2'h0);
      if (ADDR_W > 8) begin
         w_ok = w_ok && (aw_addr_reg >> 8) == '0;
         r_ok = r_ok && (ARADDR >> 8) == '0;
      end
   end

   // Write channel: address and data taken in either order
   always_comb begin
      aw_addr_next = aw_addr_reg;
      aw_have_next = aw_have_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      w_have_next = w_have_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      wr_src = '0;
      wr_dst = '0;
      wr_cnt = '0;
      wr_ctl = '0;
      do_write = aw_have_reg && w_have_reg && !bvalid_reg;
      if (AWVALID && awready_reg) begin
         aw_addr_next = AWADDR;
         aw_have_next = 1'b1;
      end
      if (WVALID && wready_reg) begin
         w_data_next = WDATA;
         w_strb_next = WSTRB;
         w_have_next = 1'b1;
      end
      if (bvalid_reg && BREADY) bvalid_next = 1'b0;
      if (do_write) begin
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = w_ok ? dcr_pkg::RESP_OKAY : dcr_pkg::RESP_SLVERR;
         if (w_ok && !w_sh) begin
            wr_src[w_ch] = (w_reg == dcr_pkg::OFS_SRC);
            wr_dst[w_ch] = (w_reg == dcr_pkg::OFS_DST);
            wr_cnt[w_ch] = (w_reg == dcr_pkg::OFS_CNT);
            wr_ctl[w_ch] = (w_reg == dcr_pkg::OFS_CTL);
         end
      end
      awready_next = !aw_have_next && !bvalid_next;
      wready_next = !w_have_next && !bvalid_next;
   end

   // Read channel: answer one cycle after the address is taken
   always_comb begin
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      rd_ctl = '0;
      if (rvalid_reg && RREADY) rvalid_next = 1'b0;
      if (ARVALID && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next = r_ok ? dcr_pkg::RESP_OKAY : dcr_pkg::RESP_SLVERR;
         rdata_next = 32'h0;
         if (r_ok && r_sh) begin
            rdata_next = 32'(sh_reg);
         end else if (r_ok) begin
            unique case (r_reg)
               dcr_pkg::OFS_SRC: rdata_next = src[r_ch];
               dcr_pkg::OFS_DST: rdata_next = dst[r_ch];
               dcr_pkg::OFS_CNT: rdata_next = cnt[r_ch];
               default: begin
                  rdata_next = ctl[r_ch];
                  rd_ctl[r_ch] = 1'b1;
               end
            endcase
         end
      end
      arready_next = !rvalid_next;
   end

   // Shared operation word: run bit and two sticky flags
   always_comb begin
      sh_next = sh_reg;
      sh_arm_next = sh_arm_reg;
      if (ARVALID && arready_reg && r_ok && r_sh) begin
         sh_arm_next = sh_arm_next | sh_reg[dcr_pkg::B_SH_FLAG+:2];
      end
      if (do_write && w_ok && w_sh) begin
         sh_next = (16'(dcr_pkg::merge(32'(sh_reg), w_data_reg, w_strb_reg)) & dcr_pkg::SH_WMASK)
                   | (sh_reg & ~dcr_pkg::SH_WMASK);
         for (int i = 0; i < 2; i++) begin
            if (w_strb_reg[0] && !w_data_reg[dcr_pkg::B_SH_FLAG+i] && sh_arm_reg[i]) begin
               sh_next[dcr_pkg::B_SH_FLAG+i] = 1'b0;
               sh_arm_next[i] = 1'b0;
            end
         end
      end
      for (int i = 0; i < 2; i++) begin
         if (FLAG_SET[i]) sh_next[dcr_pkg::B_SH_FLAG+i] = 1'b1;
      end
      for (int i = 0; i < NCH; i++) begin
         irq_next[i] = ctl[i][dcr_pkg::B_TEND] & ctl[i][dcr_pkg::B_IEN];
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         aw_addr_reg <= '0;
         aw_have_reg <= 1'b0;
         w_data_reg  <= 32'h0;
         w_strb_reg  <= 4'h0;
         w_have_reg  <= 1'b0;
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= dcr_pkg::RESP_OKAY;
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0;
         rresp_reg   <= dcr_pkg::RESP_OKAY;
         sh_reg      <= dcr_pkg::SH_RST;
         sh_arm_reg  <= 2'h0;
         irq_reg     <= 4'h0;
      end else begin
         aw_addr_reg <= aw_addr_next;
         aw_have_reg <= aw_have_next;
         w_data_reg  <= w_data_next;
         w_strb_reg  <= w_strb_next;
         w_have_reg  <= w_have_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
         sh_reg      <= sh_next;
         sh_arm_reg  <= sh_arm_next;
         irq_reg     <= irq_next;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         dcr_chan #(
            .CH    (g),
            .CNT_W (CNT_W)
         ) u_chan (
            .clk    (CLK),
            .rst    (SYS_RST),
            .wr_src (wr_src[g]),
            .wr_dst (wr_dst[g]),
            .wr_cnt (wr_cnt[g]),
            .wr_ctl (wr_ctl[g]),
            .rd_ctl (rd_ctl[g]),
            .wdata  (w_data_reg),
            .wstrb  (w_strb_reg),
            .step   (XFER_STEP[g]),
            .run_en (run_en),
            .src    (src[g]),
            .dst    (dst[g]),
            .cnt    (cnt[g]),
            .ctl    (ctl[g])
         );
      end
      for (g = 0; g < dcr_pkg::NUM_EXT; g++) begin : g_req
         dcr_reqack u_req (
            .clk        (CLK),
            .rst        (SYS_RST),
            .req_pin    (TRANSFER_REQUEST_PIN[g]),
            .enabled    (ctl[g][dcr_pkg::B_ENA] & run_en),
            .edge_sense (ctl[g][dcr_pkg::B_SENSE]),
            .pol        (ctl[g][dcr_pkg::B_REQPOL]),
            .accepted   (REQUEST_ACCEPTED_STROBE[g])
         );
      end
   endgenerate

   assign AWREADY = awready_reg;
   assign WREADY = wready_reg;
   assign BVALID = bvalid_reg;
   assign BRESP = bresp_reg;
   assign ARREADY = arready_reg;
   assign RVALID = rvalid_reg;
   assign RDATA = rdata_reg;
   assign RRESP = rresp_reg;
   assign CHANNEL_IRQ = irq_reg;
endmodule : dcr_top

// >>> testbench/dcr_monitor.sv
// Checker of read-back fields and status outputs of the register set.
// Assumes binding to dcr_top; sees only its ports.
`timescale 1ns/10ps
module dcr_monitor #(
   parameter int ADDR_W = 8
) (
   input wire logic              CLK,
   input wire logic              SYS_RST,
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic              ARVALID,
   input wire logic              ARREADY,
   input wire logic [31:0]       RDATA,
   input wire logic              AWVALID,
   input wire logic              AWREADY,
   input wire logic              BVALID,
   input wire logic [3:0]        XFER_STEP,
   input wire logic [1:0]        REQUEST_ACCEPTED_STROBE,
   input wire logic [3:0]        CHANNEL_IRQ
);
   logic wr_seen_reg;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // Set once software has issued any write
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) wr_seen_reg <= 1'b0;
      else if (AWVALID && AWREADY) wr_seen_reg <= 1'b1;
   end
   sequence s_rd_ctl;
      ARVALID && ARREADY && ARADDR[3:0] == 4'hC && ARADDR[7:4] >= 4'h2 && ARADDR[7:4] <= 4'h5;
   endsequence
   sequence s_rd_cnt;
      ARVALID && ARREADY && ARADDR[3:0] == 4'h8 && ARADDR[7:4] >= 4'h2 && ARADDR[7:4] <= 4'h5;
   endsequence
   property p_cnt_hi;
      s_rd_cnt |=> RDATA[31:24] == 8'h0;
   endproperty
   a_cnt_hi: assert property (p_cnt_hi) else $error("counter upper byte not zero");
   property p_ctl_rsv;
      s_rd_ctl |=> RDATA[31:21] == 11'h0 && !RDATA[7];
   endproperty
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("reserved control bits set");
   property p_ch23_bits;
      s_rd_ctl ##0 ARADDR[6] |=> RDATA[18:16] == 3'h0 && !RDATA[6];
   endproperty
   a_ch23_bits: assert property (p_ch23_bits) else $error("absent ch2/3 bits set");
   property p_reload_bit;
      s_rd_ctl ##0 ARADDR[7:4] != 4'h4 |=> !RDATA[19];
   endproperty
   a_reload_bit: assert property (p_reload_bit) else $error("reload bit outside ch2");
   property p_fetch_bit;
      s_rd_ctl ##0 ARADDR[7:4] != 4'h5 |=> !RDATA[20];
   endproperty
   a_fetch_bit: assert property (p_fetch_bit) else $error("fetch bit outside ch3");
   property p_ctl_rst;
      s_rd_ctl ##0 !wr_seen_reg |=> RDATA == 32'h0;
   endproperty
   a_ctl_rst: assert property (p_ctl_rst) else $error("control word not zero");
   property p_strobe_idle;
      !wr_seen_reg |-> REQUEST_ACCEPTED_STROBE == 2'h3;
   endproperty
   a_strobe_idle: assert property (p_strobe_idle) else $error("strobe active");
   property p_irq_cause;
      |(CHANNEL_IRQ & ~$past(CHANNEL_IRQ) & ~$past(XFER_STEP, 2)) |-> $past(BVALID);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without end");
endmodule : dcr_monitor

bind dcr_top dcr_monitor #(.ADDR_W(ADDR_W)) u_mon (.CLK(CLK), .SYS_RST(SYS_RST),
   .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
   .AWVALID(AWVALID), .AWREADY(AWREADY), .BVALID(BVALID), .XFER_STEP(XFER_STEP),
   .REQUEST_ACCEPTED_STROBE(REQUEST_ACCEPTED_STROBE), .CHANNEL_IRQ(CHANNEL_IRQ));

// >>> testbench/dcr_engine_model.sv
// Transfer engine stand-in: step pulses per unit and request pin drive.
// Assumes the register set's clock and an active-high reset.
`timescale 1ns/10ps
module dcr_engine_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic [1:0] ch,
   input  wire logic [3:0] units,
   input  wire logic       slow,
   input  wire logic [1:0] req_on,
   output logic      [3:0] step,
   output logic      [1:0] req_pin_n,
   output logic            busy
);
   logic [3:0] left_reg, left_next, step_reg, step_next;
   logic [1:0] gap_reg, gap_next;
   // Released pin sits at its pull-up level
   assign req_pin_n = ~req_on;
   assign busy      = left_reg != 4'h0;
   assign step      = step_reg;
   always_comb begin
      left_next = left_reg;
      gap_next  = gap_reg;
      step_next = 4'h0;
      if (go) begin
         left_next = units;
      end else if (busy && gap_reg == 2'h0) begin
         step_next[ch] = 1'b1;
         left_next     = left_reg - 4'h1;
         gap_next      = slow ? 2'h2 : 2'h0;
      end else if (gap_reg != 2'h0) begin
         gap_next = gap_reg - 2'h1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         left_reg <= 4'h0;
         step_reg <= 4'h0;
         gap_reg  <= 2'h0;
      end else begin
         left_reg <= left_next;
         step_reg <= step_next;
         gap_reg  <= gap_next;
      end
   end
endmodule : dcr_engine_model

// >>> testbench/dcr_top_test.sv
// Testbench of the register set over AXI4-Lite with an engine stand-in.
// Assumes dcr_top, dcr_engine_model and the bound checker.
`timescale 1ns/10ps
module dcr_top_test;
   logic        clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, standby;
   logic        awready, wready, bvalid, arready, rvalid, go, slow, busy;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, xfer_step, irq, units;
   logic [1:0]  bresp, rresp, flag_set, req_pin_n, strobe, eng_ch, req_on;
   int          error_cnt, checks_done;
   localparam logic [31:0] ctl_exp [4] = '{32'h7_FF7D, 32'h7_FF7D,
                                           32'h8_FF3D, 32'h10_FF3D};

   dcr_top DUT (.CLK(clk), .SYS_RST(sys_rst), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .XFER_STEP(xfer_step), .STANDBY(standby), .FLAG_SET(flag_set),
      .TRANSFER_REQUEST_PIN(req_pin_n), .REQUEST_ACCEPTED_STROBE(strobe), .CHANNEL_IRQ(irq));
   dcr_engine_model u_eng (.clk(clk), .rst(sys_rst), .go(go), .ch(eng_ch), .units(units),
      .slow(slow), .req_on(req_on), .step(xfer_step), .req_pin_n(req_pin_n), .busy(busy));

   always #5 clk = ~clk;

   task automatic stop_test;
      if (error_cnt == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tmo;
      error_cnt++;
      $display("Error at %0t: no answer", $time);
      stop_test();
   endtask : tmo

   function automatic logic [7:0] ra(input int c, input logic [3:0] o);
      return 8'h20 + 8'(c) * 8'h10 + {4'h0, o};
   endfunction : ra

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                     input logic [1:0] er = 2'h0);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er});
            return;
         end
      end
      tmo();
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      logic ar;
      ar = 1'b1;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         if (ar && arready) begin
            ar = 1'b0;
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            rready <= 1'b0;
            chk(rdata, e);
            chk({30'h0, rresp}, {30'h0, er});
            return;
         end
      end
      tmo();
   endtask : rc

   task automatic run(input logic [1:0] c, input logic [3:0] u, input logic s);
      @(posedge clk);
      eng_ch <= c;
      units  <= u;
      slow   <= s;
      go     <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (int n = 0; n < 60; n++) begin
         @(posedge clk);
         if (!busy) return;
      end
      tmo();
   endtask : run

   task automatic wstb(input logic [1:0] e);
      for (int n = 0; n < 10 && strobe !== e; n++) @(posedge clk);
      chk({30'h0, strobe}, {30'h0, e});
   endtask : wstb

   initial begin
      {clk, awvalid, wvalid, bready, arvalid, rready, standby, go, slow} = '0;
      {awaddr, araddr, wdata, wstrb, units, flag_set, eng_ch, req_on} = '0;
      error_cnt = 0;
      checks_done = 0;
      sys_rst = 1'b1;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      for (int c = 0; c < 4; c++) rc(ra(c, 4'hC), 32'h0);
      for (int c = 0; c < 4; c++) begin
         wr(ra(c, 4'hC), 32'hFFFF_FFFF);
         rc(ra(c, 4'hC), ctl_exp[c]);
         wr(ra(c, 4'hC), 32'h0);
      end
      wr(ra(0, 4'h8), 32'hFFFF_FFFF);
      rc(ra(0, 4'h8), 32'hFF_FFFF);
      wr(ra(1, 4'h0), 32'h1234_5678);
      wr(ra(1, 4'h0), 32'hAAAA_BBBB, 4'hC);
      rc(ra(1, 4'h0), 32'hAAAA_5678);
      wr(8'h10, 32'h1, 4'hF, 2'h2);
      rc(8'h10, 32'h0, 2'h2);
      wr(8'h60, 32'h1);
      flag_set <= 2'h1;
      @(posedge clk);
      flag_set <= 2'h0;
      rc(8'h60, 32'h3);
      wr(8'h60, 32'h1);
      rc(8'h60, 32'h1);
      wr(ra(0, 4'h0), 32'h100);
      wr(ra(0, 4'h4), 32'h200);
      wr(ra(0, 4'h8), 32'h3);
      wr(ra(0, 4'hC), 32'h9015);
      run(2'h0, 4'h1, 1'b0);
      rc(ra(0, 4'h0), 32'h104);
      rc(ra(0, 4'h4), 32'h1FC);
      rc(ra(0, 4'h8), 32'h2);
      standby <= 1'b1;
      run(2'h0, 4'h1, 1'b0);
      standby <= 1'b0;
      rc(ra(0, 4'h0), 32'h104);
      run(2'h0, 4'h2, 1'b0);
      rc(ra(0, 4'h8), 32'h0);
      rc(ra(0, 4'hC), 32'h9017);
      chk({28'h0, irq}, 32'h1);
      run(2'h0, 4'h1, 1'b1);
      rc(ra(0, 4'h0), 32'h10C);
      wr(ra(0, 4'hC), 32'h9015);
      rc(ra(0, 4'hC), 32'h9015);
      wr(ra(0, 4'hC), 32'h9017);
      rc(ra(0, 4'hC), 32'h9015);
      wr(ra(1, 4'h0), 32'h1000);
      wr(ra(1, 4'h4), 32'h2000);
      wr(ra(1, 4'h8), 32'h0);
      wr(ra(1, 4'hC), 32'h5019);
      run(2'h1, 4'h1, 1'b1);
      rc(ra(1, 4'h0), 32'h1010);
      rc(ra(1, 4'h4), 32'h2010);
      rc(ra(1, 4'h8), 32'hFF_FFFF);
      wr(ra(2, 4'h0), 32'h40);
      wr(ra(2, 4'h8), 32'hA);
      wr(ra(2, 4'hC), 32'h8_1001);
      run(2'h2, 4'h3, 1'b0);
      rc(ra(2, 4'h0), 32'h43);
      run(2'h2, 4'h1, 1'b0);
      rc(ra(2, 4'h0), 32'h40);
      wr(ra(3, 4'h0), 32'h80);
      wr(ra(3, 4'h8), 32'h5);
      wr(ra(3, 4'hC), 32'h10_1001);
      run(2'h3, 4'h2, 1'b1);
      rc(ra(3, 4'h0), 32'h88);
      wr(ra(0, 4'hC), 32'h4_0001);
      req_on <= 2'h1;
      wstb(2'h3);
      wr(ra(0, 4'hC), 32'h1);
      wstb(2'h2);
      req_on <= 2'h0;
      wstb(2'h3);
      stop_test();
   end
endmodule : dcr_top_test
